// file: core/nvr_defs.svh
// constants for the nonvolatile data register interface
`ifndef NVR_DEFS_SVH
`define NVR_DEFS_SVH
`define NVR_CTRL_OFS       8'h40
`define NVR_BANK_CTRL      1'b1
`define NVR_BANK_DIRECT    1'b0
`define NVR_ADDR_OFS       8'h1e
`define NVR_DATA_OFS       8'h1f
`define NVR_ADDR_W_LARGE   7
`define NVR_ADDR_W_SMALL   6
`define NVR_DEPTH_LARGE    128
`define NVR_BIT_PGM_EN     3
`define NVR_BIT_PGM_GO     2
`define NVR_BIT_FETCH_EN   1
`define NVR_BIT_FETCH_GO   0
`define NVR_RST_BYTE       8'h00
`define NVR_CTRL_MASK      8'h0f
`define NVR_AMASK_LARGE    8'h7f
`define NVR_AMASK_SMALL    8'h3f
`define NVR_PGM_CYCLES     16'h0004
`define NVR_CNT_ZERO       16'h0000
`define NVR_CNT_ONE        16'h0001
`endif

// file: core/nvr_pkg.sv
// types for the nonvolatile data register interface
package nvr_pkg;
  typedef logic [7:0] nvr_byte_t;
  typedef enum logic [1:0] {NVR_IDLE, NVR_FETCH, NVR_PROGRAM} nvr_state_e;
endpackage : nvr_pkg

// file: core/nvr_core.sv
// nonvolatile data memory with address, data and control registers
`timescale 1ns/1ns
`include "nvr_defs.svh"
module nvr_core #(
  parameter bit LARGE = 1'b1
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire logic              sfr_bank,
  input  wire logic [7:0]        sfr_addr,
  input  wire nvr_pkg::nvr_byte_t sfr_wdata,
  output nvr_pkg::nvr_byte_t     sfr_rdata,
  output logic                   nv_busy
);
  import nvr_pkg::*;

  nvr_byte_t   nv_address_reg;
  nvr_byte_t   nv_address_next;
  nvr_byte_t   nv_data_reg;
  nvr_byte_t   nv_data_next;
  nvr_byte_t   nv_control_reg;
  nvr_byte_t   ctrl_next;
  nvr_state_e  state_reg;
  nvr_state_e  state_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  // sized for the large variant; the small one leaves the top half unused
  nvr_byte_t   mem [0:`NVR_DEPTH_LARGE-1];

  // the control register only answers through the bank 1 window
  wire in_bank0 = (sfr_bank == `NVR_BANK_DIRECT);
  wire in_bank1 = (sfr_bank == `NVR_BANK_CTRL);
  wire hit_addr = in_bank0 && (sfr_addr == `NVR_ADDR_OFS);
  wire hit_data = in_bank0 && (sfr_addr == `NVR_DATA_OFS);
  wire hit_ctrl = in_bank1 && (sfr_addr == `NVR_CTRL_OFS);

  // a write only lands on an enabled edge
  wire wr_addr = clk_en && sfr_wr && hit_addr;
  wire wr_data = clk_en && sfr_wr && hit_data;
  wire wr_ctrl = clk_en && sfr_wr && hit_ctrl;

  // unimplemented address bits never reach the array
  wire [7:0] addr_mask = LARGE ? `NVR_AMASK_LARGE :
                                 `NVR_AMASK_SMALL;
  wire [7:0] addr_eff  = nv_address_reg & addr_mask;
  wire [`NVR_ADDR_W_LARGE-1:0] mem_idx =
    addr_eff[`NVR_ADDR_W_LARGE-1:0];

  wire idle     = (state_reg == NVR_IDLE);
  wire in_fetch = (state_reg == NVR_FETCH);
  wire in_pgm   = (state_reg == NVR_PROGRAM);
  wire pgm_en   = nv_control_reg[`NVR_BIT_PGM_EN];
  wire pgm_go   = nv_control_reg[`NVR_BIT_PGM_GO];
  wire fetch_en = nv_control_reg[`NVR_BIT_FETCH_EN];
  wire fetch_go = nv_control_reg[`NVR_BIT_FETCH_GO];

  // a go bit without its enable just waits; program beats fetch
  wire go_pgm   = idle && pgm_en && pgm_go;
  wire go_fetch = idle && !go_pgm && fetch_en && fetch_go;
  wire cnt_done = (cnt_reg == `NVR_CNT_ONE);
  wire pgm_end  = in_pgm && cnt_done;
  wire pgm_wr   = clk_en && pgm_end;

  // read path stays combinational so software sees it the same cycle
  wire [7:0] rd_addr_val = addr_eff;
  wire [7:0] rd_data_val = nv_data_reg;
  wire [7:0] rd_ctrl_val = nv_control_reg & `NVR_CTRL_MASK;
  wire [7:0] rd_sel_val  = hit_addr ? rd_addr_val :
                           hit_data ? rd_data_val :
                           hit_ctrl ? rd_ctrl_val :
                           `NVR_RST_BYTE;

  assign nv_busy   = !idle;
  assign sfr_rdata = sfr_rd ? rd_sel_val : `NVR_RST_BYTE;

  always_comb
  begin
    nv_address_next = nv_address_reg;
    if (wr_addr)
      nv_address_next = sfr_wdata & addr_mask;
  end

  // a fetch result wins over a software write in the same cycle
  always_comb
  begin
    nv_data_next = nv_data_reg;
    if (in_fetch)
      nv_data_next = mem[mem_idx];
    else if (wr_data)
      nv_data_next = sfr_wdata;
  end

  // software writes the control byte; hardware clears go bits at end
  always_comb
  begin
    ctrl_next = nv_control_reg;
    if (wr_ctrl)
      ctrl_next = sfr_wdata & `NVR_CTRL_MASK;
    if (in_fetch)
      ctrl_next[`NVR_BIT_FETCH_GO] = 1'b0;
    if (pgm_end)
      ctrl_next[`NVR_BIT_PGM_GO] = 1'b0;
  end

  // program time is a short fixed count, not a real cell's timing
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      NVR_IDLE:
        if (go_pgm)
        begin
          state_next = NVR_PROGRAM;
          cnt_next   = `NVR_PGM_CYCLES;
        end
        else if (go_fetch)
          state_next = NVR_FETCH;
      NVR_FETCH:
        state_next = NVR_IDLE;
      NVR_PROGRAM:
        if (cnt_done)
        begin
          state_next = NVR_IDLE;
          cnt_next   = `NVR_CNT_ZERO;
        end
        else
          cnt_next = cnt_reg - `NVR_CNT_ONE;
      default:
      begin
        state_next = NVR_IDLE;
        cnt_next   = `NVR_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      nv_address_reg <= `NVR_RST_BYTE;
    else if (clk_en)
      nv_address_reg <= nv_address_next;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      nv_data_reg <= `NVR_RST_BYTE;
    else if (clk_en)
      nv_data_reg <= nv_data_next;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      nv_control_reg <= `NVR_RST_BYTE;
    else if (clk_en)
      nv_control_reg <= ctrl_next;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= NVR_IDLE;
      cnt_reg   <= `NVR_CNT_ZERO;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // array contents survive reset, as a nonvolatile store would
  always_ff @(posedge clk_sys)
  begin
    if (pgm_wr)
      mem[mem_idx] <= nv_data_reg;
  end

endmodule : nvr_core

// file: verification/nvr_core_properties.sv
// port assertions for the nonvolatile register interface
`timescale 1ns/1ns
module nvr_core_properties #(parameter bit LARGE = 1'b1) (
  input wire logic               clk_sys,
  input wire logic               resetn,
  input wire logic               clk_en,
  input wire logic               sfr_wr,
  input wire logic               sfr_rd,
  input wire logic               sfr_bank,
  input wire logic [7:0]         sfr_addr,
  input wire nvr_pkg::nvr_byte_t sfr_wdata,
  input wire nvr_pkg::nvr_byte_t sfr_rdata,
  input wire logic               nv_busy
);
  import nvr_pkg::*;
  localparam nvr_byte_t AMASK = LARGE ? 8'h7f : 8'h3f;
  wire w_ok  = sfr_wr & clk_en;
  wire ctl_w = w_ok & sfr_bank & sfr_addr == 8'h40 & !nv_busy;
  wire adr_w = w_ok & !sfr_bank & sfr_addr == 8'h1e;
  wire dat_w = w_ok & !sfr_bank & sfr_addr == 8'h1f & !nv_busy;
  wire adr_r = sfr_rd & !sfr_bank & sfr_addr == 8'h1e;
  wire dat_r = sfr_rd & !sfr_bank & sfr_addr == 8'h1f;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_pgm; ctl_w && sfr_wdata[3:2] == 2'b11; endsequence
  sequence s_fetch; ctl_w && sfr_wdata[3:0] == 4'h3; endsequence
  property p_pgm; s_pgm |=> ##1 nv_busy [*4] ##1 !nv_busy; endproperty
  property p_fetch; s_fetch |=> ##1 nv_busy ##1 !nv_busy; endproperty
  property p_no_pgm;
    ctl_w && sfr_wdata[3:2] == 2'b01 && !sfr_wdata[0] |=> ##1 !nv_busy;
  endproperty
  property p_dat;
    dat_w ##2 dat_r |-> sfr_rdata == $past(sfr_wdata, 2);
  endproperty
  property p_adr;
    adr_w ##2 adr_r |-> sfr_rdata == ($past(sfr_wdata, 2) & AMASK);
  endproperty
  property p_adr_hi; adr_r |-> (sfr_rdata & ~AMASK) == 8'h00; endproperty
  property p_ctl_hi;
    sfr_rd && sfr_bank && sfr_addr == 8'h40 |-> sfr_rdata[7:4] == 4'h0;
  endproperty
  property p_idle; !sfr_rd |-> sfr_rdata == 8'h00; endproperty
  a_pgm: assert property (p_pgm) else $error("program length");
  a_fetch: assert property (p_fetch) else $error("fetch length");
  a_no_pgm: assert property (p_no_pgm) else $error("unguarded");
  a_dat: assert property (p_dat) else $error("data readback");
  a_adr: assert property (p_adr) else $error("addr readback");
  a_adr_hi: assert property (p_adr_hi) else $error("addr high");
  a_ctl_hi: assert property (p_ctl_hi) else $error("ctrl high");
  a_idle: assert property (p_idle) else $error("idle read data");
endmodule : nvr_core_properties
bind nvr_core nvr_core_properties #(.LARGE(LARGE)) u_prop (
  .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_bank(sfr_bank), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .nv_busy(nv_busy));

// file: verification/eeprom_data_register_interface_test.sv
// self-checking bench for the nonvolatile register interface
`timescale 1ns/1ns
module eeprom_data_register_interface_test;
  import nvr_pkg::*;
  logic       clk_sys = 0, resetn = 0, clk_en = 1, sfr_wr = 0, sfr_rd = 0;
  logic       sfr_bank = 0, nv_busy;
  logic [7:0] sfr_addr = 0;
  nvr_byte_t  sfr_wdata = 0, sfr_rdata, a, d;
  int         err_total = 0, checked = 0;
  nvr_core u_dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_bank(sfr_bank),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .nv_busy(nv_busy));
  initial forever #10 clk_sys = ~clk_sys;
  task chk(input nvr_byte_t seen, exp, input string nm);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task give_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // read held to the next edge so the checker sees it too
  task rd(input logic b, input nvr_byte_t ad, ex, input string nm);
    {sfr_bank, sfr_addr, sfr_rd} = {b, ad, 1'b1};
    #1 chk(sfr_rdata, ex, nm);
    @(posedge clk_sys) #2;
    sfr_rd = 0;
    @(posedge clk_sys) #2;
  endtask : rd
  task wr(input logic b, input nvr_byte_t ad, dt);
    {sfr_bank, sfr_addr, sfr_wdata, sfr_wr} = {b, ad, dt, 1'b1};
    @(posedge clk_sys) #2;
    sfr_wr = 0;
    @(posedge clk_sys) #2;
  endtask : wr
  task wait_idle;
    repeat (20) if (nv_busy === 1'b1) @(posedge clk_sys) #2;
    if (nv_busy !== 1'b0)
    begin
      err_total++;
      give_verdict;
    end
  endtask : wait_idle
  initial
  begin
    void'($urandom(32'h4385));
    repeat (2) @(posedge clk_sys);
    #2 resetn = 1;
    rd(0, 8'h1e, 8'h00, "addr reset");
    rd(0, 8'h1f, 8'h00, "data reset");
    rd(1, 8'h40, 8'h00, "ctrl reset");
    rd(0, 8'h20, 8'h00, "unmapped");
    wr(1, 8'h40, 8'hf4);
    chk({7'h0, nv_busy}, 8'h00, "unguarded start");
    rd(1, 8'h40, 8'h04, "ctrl upper");
    for (int i = 0; i < 6; i++)
    begin
      a = i ? 8'($urandom) : 8'hff;
      d = 8'($urandom);
      wr(0, 8'h1e, a);
      rd(0, 8'h1e, a & 8'h7f, "addr mask");
      wr(0, 8'h1f, d);
      rd(0, 8'h1f, d, "data rw");
      wr(1, 8'h40, 8'h0c);
      wait_idle;
      rd(1, 8'h40, 8'h08, "go cleared");
      wr(0, 8'h1f, ~d);
      wr(0, 8'h1e, a ^ 8'h80);
      wr(1, 8'h40, 8'h03);
      wait_idle;
      rd(0, 8'h1f, d, "fetched");
    end
    wr(0, 8'h1f, 8'h5a);
    wr(1, 8'h40, 8'h04);
    wr(1, 8'h40, 8'h03);
    wait_idle;
    rd(0, 8'h1f, d, "protected");
    give_verdict;
  end
endmodule : eeprom_data_register_interface_test
